//--- rtl/cbr_config_regs.sv
// card bridge configuration registers with event interrupt
// assumes one clock, synchronous active-low host reset, and a
// single-cycle register port whose read data follow one cycle later
`timescale 1ns/1ps
`default_nettype none

module cbr_config_regs (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // controls from other configuration blocks
   input  wire logic        subsys_write_enable_in,
   input  wire logic        host_serr_enable_in,
   // card-side events
   input  wire logic        card_system_error_n_in,
   input  wire logic        parity_error_detect_in,
   input  wire logic        master_abort_in,
   // host cycle decode
   input  wire logic [31:0] cycle_addr_in,
   input  wire logic        cycle_io_in,
   input  wire logic        cycle_mem_in,
   input  wire logic        cycle_socket_in,
   // outputs
   output logic             write_post_enable_out,
   output logic      [1:0]  window1_prefetchable_out,
   output logic             window0_prefetchable_out,
   output logic             func_irq_route_sel_out,
   output logic             card_reset_n_out,
   output logic             target_abort_out,
   output logic             host_serr_out,
   output logic             card_parity_error_n_out,
   output logic             card_parity_error_oe_out,
   output logic             vga_forward_hit_out,
   output logic             isa_range_block_out,
   output logic             index_port_hit_out,
   output logic             data_port_hit_out,
   output logic      [1:0]  irq_signal_mode_sel_out,
   output logic             irq_out
);

   localparam int NEV = cbr_pkg::EV_COUNT;

   typedef struct packed {
      logic            post;
      logic [1:0]      win1_pf;
      logic            win0_pf;
      logic            route;
      logic            card_reset_out;
      logic            mabt;
      logic            vga;
      logic [1:0]      isa;
      logic            serr_en;
      logic            perr_en;
      logic [15:0]     maker_id;
      logic [15:0]     product_id;
      logic [31:1]     legacy_base;
      logic [1:0]      mode;
      logic            sock_sel;
      logic [NEV-1:0]  ev_status;
      logic [NEV-1:0]  ev_mask;
      logic [31:0]     rdata;
      logic            irq;
      logic            card_reset_n;
      logic            target_abort;
      logic            host_serr;
      logic            perr_drive;
      logic            vga_hit;
      logic            isa_block;
      logic            index_hit;
      logic            data_hit;
      logic            syserr_prev;
   } cbr_state_s;

   cbr_state_s st;
   cbr_state_s next_st;

   logic            syserr_sync_n;
   logic            syserr_rise;
   logic [NEV-1:0]  ev_set;
   logic [15:0]     bridge_view;
   logic [7:0]      pin_view;
   logic            wr_bc;
   logic            io_hit_vga;
   logic            mem_hit_vga;

   // -----------------------------------------------------------------
   // pin synchroniser
   // -----------------------------------------------------------------
   cbr_sync2 #(
      .WIDTH          (1)
   ) u_syserr_sync (
      .ref_clk_in     (ref_clk_in),
      .rst_n_in       (rst_n_in),
      .async_in       (card_system_error_n_in),
      .reset_value_in (1'b1),
      .sync_out       (syserr_sync_n)
   );

   // -----------------------------------------------------------------
   // read views
   // -----------------------------------------------------------------
   always_comb begin
      bridge_view                   = 16'h0000;
      bridge_view[cbr_pkg::BC_POST]  = st.post;
      bridge_view[cbr_pkg::BC_PF1]   = st.win1_pf[st.sock_sel];
      bridge_view[cbr_pkg::BC_PF0]   = st.win0_pf;
      bridge_view[cbr_pkg::BC_ROUTE] = st.route;
      bridge_view[cbr_pkg::BC_CARD_RESET_OUT]  = st.card_reset_out;
      bridge_view[cbr_pkg::BC_MABT]  = st.mabt;
      bridge_view[cbr_pkg::BC_VGA]   = st.vga;
      bridge_view[cbr_pkg::BC_ISA]   = st.isa[st.sock_sel];
      bridge_view[cbr_pkg::BC_SERR]  = st.serr_en;
      bridge_view[cbr_pkg::BC_PERR]  = st.perr_en;
      // parallel ISA signalling leaves no PCI pin in use
      if (st.mode == cbr_pkg::MODE_PARALLEL_ISA) begin
         pin_view = cbr_pkg::PIN_NONE;
      end else begin
         pin_view = cbr_pkg::PIN_INTA;
      end
   end

   // -----------------------------------------------------------------
   // event detection
   // -----------------------------------------------------------------
   assign syserr_rise = st.syserr_prev & ~syserr_sync_n;
   assign ev_set[cbr_pkg::EV_SYSERR] = syserr_rise;
   assign ev_set[cbr_pkg::EV_PARITY] = parity_error_detect_in;
   assign ev_set[cbr_pkg::EV_MABORT] = master_abort_in;

   // -----------------------------------------------------------------
   // address decode of host cycles
   // -----------------------------------------------------------------
   assign mem_hit_vga = cycle_mem_in
                     && cycle_addr_in[31:17] == cbr_pkg::VGA_MEM_TAG;
   assign io_hit_vga  = cycle_io_in
                     && ((cycle_addr_in[31:4] == cbr_pkg::VGA_IO_TAG_A
                       && cycle_addr_in[3:0] <= cbr_pkg::VGA_IO_TOP_A)
                      || cycle_addr_in[31:5] == cbr_pkg::VGA_IO_TAG_B);

   assign wr_bc = reg_wr_in && reg_addr_in == cbr_pkg::OFS_BRIDGE_CTL;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.syserr_prev = syserr_sync_n;

      // register writes; read-only bits never take write data
      if (wr_bc) begin
         next_st.post    = reg_wdata_in[cbr_pkg::BC_POST];
         next_st.win0_pf = reg_wdata_in[cbr_pkg::BC_PF0];
         next_st.route   = reg_wdata_in[cbr_pkg::BC_ROUTE];
         next_st.card_reset_out    = reg_wdata_in[cbr_pkg::BC_CARD_RESET_OUT];
         next_st.mabt    = reg_wdata_in[cbr_pkg::BC_MABT];
         next_st.vga     = reg_wdata_in[cbr_pkg::BC_VGA];
         next_st.serr_en = reg_wdata_in[cbr_pkg::BC_SERR];
         next_st.perr_en = reg_wdata_in[cbr_pkg::BC_PERR];
         next_st.win1_pf[st.sock_sel] =
            reg_wdata_in[cbr_pkg::BC_PF1];
         next_st.isa[st.sock_sel] =
            reg_wdata_in[cbr_pkg::BC_ISA];
      end
      if (reg_wr_in && subsys_write_enable_in) begin
         if (reg_addr_in == cbr_pkg::OFS_MAKER_ID) begin
            next_st.maker_id = reg_wdata_in[15:0];
         end
         if (reg_addr_in == cbr_pkg::OFS_PRODUCT_ID) begin
            next_st.product_id = reg_wdata_in[15:0];
         end
      end
      if (reg_wr_in && reg_addr_in == cbr_pkg::OFS_LEGACY_BASE) begin
         next_st.legacy_base = reg_wdata_in[31:1];
      end
      if (reg_wr_in && reg_addr_in == cbr_pkg::OFS_EVENT_MASK) begin
         next_st.ev_mask = reg_wdata_in[NEV-1:0];
      end
      if (reg_wr_in && reg_addr_in == cbr_pkg::OFS_SOCKET_SEL) begin
         next_st.sock_sel = reg_wdata_in[0];
      end
      if (reg_wr_in && reg_addr_in == cbr_pkg::OFS_DEVICE_CTL) begin
         next_st.mode = reg_wdata_in[1:0];
      end

      // reads; data stand only in the following cycle
      next_st.rdata = 32'h00000000;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            cbr_pkg::OFS_IRQ_PIN: begin
               next_st.rdata = {24'h000000, pin_view};
            end
            cbr_pkg::OFS_BRIDGE_CTL: begin
               next_st.rdata = {16'h0000, bridge_view};
            end
            cbr_pkg::OFS_MAKER_ID: begin
               next_st.rdata = {16'h0000, st.maker_id};
            end
            cbr_pkg::OFS_PRODUCT_ID: begin
               next_st.rdata = {16'h0000, st.product_id};
            end
            cbr_pkg::OFS_LEGACY_BASE: begin
               next_st.rdata = {st.legacy_base, 1'b1};
            end
            cbr_pkg::OFS_EVENT_STATUS: begin
               next_st.rdata = {{(32-NEV){1'b0}}, st.ev_status};
            end
            cbr_pkg::OFS_EVENT_MASK: begin
               next_st.rdata = {{(32-NEV){1'b0}}, st.ev_mask};
            end
            cbr_pkg::OFS_SOCKET_SEL: begin
               next_st.rdata = {31'h00000000, st.sock_sel};
            end
            cbr_pkg::OFS_DEVICE_CTL: begin
               next_st.rdata = {30'h00000000, st.mode};
            end
            default: begin
               next_st.rdata = 32'h00000000;
            end
         endcase
      end

      // sticky events: a read clears, a new event in the same cycle wins
      if (reg_rd_in && reg_addr_in == cbr_pkg::OFS_EVENT_STATUS) begin
         next_st.ev_status = ev_set;
      end else begin
         next_st.ev_status = st.ev_status | ev_set;
      end
      next_st.irq = |(next_st.ev_status & next_st.ev_mask);

      // card reset follows bit 6, inverted, on the same edge as the write
      next_st.card_reset_n = ~next_st.card_reset_out;

      // error reporting
      next_st.target_abort = master_abort_in & st.mabt;
      next_st.host_serr = (syserr_rise & st.serr_en)
                        | (master_abort_in & st.mabt
                           & host_serr_enable_in);
      next_st.perr_drive = parity_error_detect_in & st.perr_en;

      // cycle decode
      next_st.vga_hit   = st.vga & (mem_hit_vga | io_hit_vga);
      next_st.isa_block = cycle_io_in
                        && st.isa[cycle_socket_in]
                        && cycle_addr_in[31:16] == 16'h0000
                        && cycle_addr_in[9:8] != 2'h0;
      next_st.index_hit = cycle_io_in
                        && cycle_addr_in[31:1] == st.legacy_base
                        && !cycle_addr_in[0];
      next_st.data_hit  = cycle_io_in
                        && cycle_addr_in[31:1] == st.legacy_base
                        && cycle_addr_in[0];
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st              <= '0;
         st.post         <= cbr_pkg::RST_BRIDGE_CTL[cbr_pkg::BC_POST];
         st.win1_pf      <= {2{cbr_pkg::RST_BRIDGE_CTL[cbr_pkg::BC_PF1]}};
         st.win0_pf      <= cbr_pkg::RST_BRIDGE_CTL[cbr_pkg::BC_PF0];
         st.route        <= cbr_pkg::RST_BRIDGE_CTL[cbr_pkg::BC_ROUTE];
         st.card_reset_out         <= cbr_pkg::RST_BRIDGE_CTL[cbr_pkg::BC_CARD_RESET_OUT];
         st.card_reset_n <= 1'b0;
         st.maker_id     <= cbr_pkg::RST_MAKER_ID;
         st.product_id   <= cbr_pkg::RST_PRODUCT_ID;
         st.legacy_base  <= cbr_pkg::RST_LEGACY_BASE[31:1];
         st.mode         <= cbr_pkg::RST_MODE;
         st.syserr_prev  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata_out            = st.rdata;
   assign write_post_enable_out    = st.post;
   assign window1_prefetchable_out = st.win1_pf;
   assign window0_prefetchable_out = st.win0_pf;
   assign func_irq_route_sel_out   = st.route;
   assign card_reset_n_out         = st.card_reset_n;
   assign target_abort_out         = st.target_abort;
   assign host_serr_out            = st.host_serr;
   assign card_parity_error_n_out  = ~st.perr_drive;
   assign card_parity_error_oe_out = st.perr_drive;
   assign vga_forward_hit_out      = st.vga_hit;
   assign isa_range_block_out      = st.isa_block;
   assign index_port_hit_out       = st.index_hit;
   assign data_port_hit_out        = st.data_hit;
   assign irq_signal_mode_sel_out  = st.mode;
   assign irq_out                  = st.irq;

endmodule : cbr_config_regs

`default_nettype wire

//--- rtl/cbr_pkg.sv
// constants for the card bridge configuration register group
// assumes a byte-addressed plain register port with 32-bit data
package cbr_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_IRQ_PIN      = 8'h3D;
   localparam logic [7:0] OFS_BRIDGE_CTL   = 8'h3E;
   localparam logic [7:0] OFS_MAKER_ID     = 8'h40;
   localparam logic [7:0] OFS_PRODUCT_ID   = 8'h42;
   localparam logic [7:0] OFS_LEGACY_BASE  = 8'h44;
   localparam logic [7:0] OFS_EVENT_STATUS = 8'h88;
   localparam logic [7:0] OFS_EVENT_MASK   = 8'h8C;
   localparam logic [7:0] OFS_SOCKET_SEL   = 8'h90;
   localparam logic [7:0] OFS_DEVICE_CTL   = 8'h92;

   // -----------------------------------------------------------------
   // bridge control bit positions
   // -----------------------------------------------------------------
   localparam int BC_POST    = 10;
   localparam int BC_PF1     = 9;
   localparam int BC_PF0     = 8;
   localparam int BC_ROUTE   = 7;
   localparam int BC_CARD_RESET_OUT    = 6;
   localparam int BC_MABT    = 5;
   localparam int BC_VGA     = 3;
   localparam int BC_ISA     = 2;
   localparam int BC_SERR    = 1;
   localparam int BC_PERR    = 0;

   // -----------------------------------------------------------------
   // event status bit positions
   // -----------------------------------------------------------------
   localparam int EV_SYSERR  = 0;
   localparam int EV_PARITY  = 1;
   localparam int EV_MABORT  = 2;
   localparam int EV_COUNT   = 3;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_BRIDGE_CTL  = 16'h0340;
   localparam logic [31:0] RST_LEGACY_BASE = 32'h00000001;
   // identification reset values are arbitrary
   localparam logic [15:0] RST_MAKER_ID    = 16'h5A5A;
   localparam logic [15:0] RST_PRODUCT_ID  = 16'hA5A5;
   localparam logic [7:0]  PIN_INTA        = 8'h01;
   localparam logic [7:0]  PIN_NONE        = 8'h00;

   // -----------------------------------------------------------------
   // interrupt signalling modes
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_PARALLEL_ISA = 2'h0;
   localparam logic [1:0] MODE_SERIAL_ISA   = 2'h1;
   localparam logic [1:0] MODE_SERIAL_BOTH  = 2'h2;
   localparam logic [1:0] MODE_PARALLEL_PCI = 2'h3;
   localparam logic [1:0] RST_MODE          = MODE_SERIAL_BOTH;

   // -----------------------------------------------------------------
   // address ranges
   // -----------------------------------------------------------------
   localparam logic [14:0] VGA_MEM_TAG  = 15'h0005;
   localparam logic [27:0] VGA_IO_TAG_A = 28'h000003B;
   localparam logic [3:0]  VGA_IO_TOP_A = 4'hB;
   localparam logic [26:0] VGA_IO_TAG_B = 27'h000001E;

endpackage : cbr_pkg

//--- rtl/cbr_sync2.sv
// two-flop synchroniser for pin inputs
// assumes inputs may change at any time relative to ref_clk_in
`timescale 1ns/1ps
`default_nettype none

module cbr_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_value_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } cbr_sync_s;

   cbr_sync_s st;
   cbr_sync_s next_st;

   // -----------------------------------------------------------------
   // two stages
   // -----------------------------------------------------------------
   always_comb begin
      next_st.meta   = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st <= {2{reset_value_in}};
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;

endmodule : cbr_sync2

`default_nettype wire

//--- tb/cbr_card_model.sv
// card socket model raising error and abort events on command
// assumes commands arrive just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module cbr_card_model (
   input  wire logic       ref_clk_in,
   input  wire logic [2:0] fire_in,
   output logic            card_system_error_n_out,
   output logic            parity_error_out,
   output logic            master_abort_out
);
   logic [1:0] low_cnt;
   initial begin
      low_cnt = 2'h0;
      card_system_error_n_out = 1'b1;
      parity_error_out = 1'b0;
      master_abort_out = 1'b0;
   end
   // pin pulled up when released; parity and abort pulses last one cycle, system error stays low three
   always @(posedge ref_clk_in) begin
      parity_error_out <= fire_in[1];
      master_abort_out <= fire_in[2];
      low_cnt <= fire_in[0] ? 2'h3 : low_cnt - 2'(low_cnt != 2'h0);
      card_system_error_n_out <= !(fire_in[0] || low_cnt > 2'h1);
   end
endmodule : cbr_card_model

`default_nettype wire

//--- tb/cbr_config_regs_bench.sv
// self-checking bench for the card bridge register group
// assumes cbr_pkg, the design, the checker and the card model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module cbr_config_regs_bench;
   logic        ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, seen;
   logic [7:0]  reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, cycle_addr_in, d, base;
   logic        subsys_write_enable_in, host_serr_enable_in;
   logic        card_system_error_n_in, parity_error_detect_in;
   logic        master_abort_in, cycle_io_in, cycle_mem_in;
   logic        cycle_socket_in, write_post_enable_out, host_serr_out;
   logic [1:0]  window1_prefetchable_out, irq_signal_mode_sel_out;
   logic        window0_prefetchable_out, func_irq_route_sel_out;
   logic        card_reset_n_out, target_abort_out, irq_out;
   logic        card_parity_error_n_out, card_parity_error_oe_out;
   logic        vga_forward_hit_out, isa_range_block_out;
   logic        index_port_hit_out, data_port_hit_out;
   logic [2:0]  fire;
   logic [15:0] bc, mk, pr;
   logic [15:0] bcs [2];
   int          fail_count, n_tests, sel;

   cbr_config_regs u_cbr_config_regs (.ref_clk_in, .rst_n_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .subsys_write_enable_in, .host_serr_enable_in,
      .card_system_error_n_in, .parity_error_detect_in, .master_abort_in,
      .cycle_addr_in, .cycle_io_in, .cycle_mem_in, .cycle_socket_in,
      .write_post_enable_out, .window1_prefetchable_out,
      .window0_prefetchable_out, .func_irq_route_sel_out,
      .card_reset_n_out, .target_abort_out, .host_serr_out,
      .card_parity_error_n_out, .card_parity_error_oe_out,
      .vga_forward_hit_out, .isa_range_block_out, .index_port_hit_out,
      .data_port_hit_out, .irq_signal_mode_sel_out, .irq_out);
   cbr_card_model u_cbr_card_model (.ref_clk_in, .fire_in(fire),
      .card_system_error_n_out(card_system_error_n_in),
      .parity_error_out(parity_error_detect_in),
      .master_abort_out(master_abort_in));

   // ----------------------------------------------------------------
   // bus tasks and reference model
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      `CHK("rdata", e, reg_rdata_out)
   endtask : rd
   task automatic wr_bc(input int s, input logic [15:0] v);
      sel = s;
      wr(cbr_pkg::OFS_SOCKET_SEL, 32'(s));
      wr(cbr_pkg::OFS_BRIDGE_CTL, {16'h0, v});
      bc = v;
      bcs[s] = v;
   endtask : wr_bc
   task automatic cyc(input logic io, mem, input logic [31:0] a);
      cycle_io_in <= io;
      cycle_mem_in <= mem;
      cycle_addr_in <= a;
      @(posedge ref_clk_in);
      cycle_io_in <= 1'b0;
      cycle_mem_in <= 1'b0;
      #1;
   endtask : cyc
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, cycle_io_in, cycle_mem_in} = '0;
      {reg_addr_in, reg_wdata_in, cycle_addr_in, fire} = '0;
      {subsys_write_enable_in, host_serr_enable_in, cycle_socket_in} = '0;
      {fail_count, n_tests, sel} = '0;
      bc = cbr_pkg::RST_BRIDGE_CTL;
      bcs = '{bc, bc};
      mk = cbr_pkg::RST_MAKER_ID;
      pr = cbr_pkg::RST_PRODUCT_ID;
      void'($urandom(32'h0844));
      repeat (16) @(posedge ref_clk_in);
      #1;
      `CHK("card_reset_out", 1'b0, card_reset_n_out)
      `CHK("win", 3'h7, {window1_prefetchable_out, window0_prefetchable_out})
      rst_n_in <= 1'b1;
      rd(cbr_pkg::OFS_IRQ_PIN, 32'h1);
      rd(cbr_pkg::OFS_BRIDGE_CTL, 32'h0340);
      rd(cbr_pkg::OFS_LEGACY_BASE, 32'h1);
      rd(8'h50, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr_bc(i % 2, 16'($urandom));
         rd(cbr_pkg::OFS_BRIDGE_CTL, {16'h0, bc & 16'h05EB | bcs[sel] & 16'h0204});
         `CHK("post", bc[10], write_post_enable_out)
         `CHK("win1", bcs[sel][9], window1_prefetchable_out[sel])
         `CHK("route", bc[7], func_irq_route_sel_out)
         `CHK("card_reset_out", !bc[6], card_reset_n_out)
      end
      for (int m = 0; m < 4; m++) begin
         wr(cbr_pkg::OFS_DEVICE_CTL, 32'(m));
         `CHK("mode", 2'(m), irq_signal_mode_sel_out)
         wr(cbr_pkg::OFS_IRQ_PIN, $urandom);
         rd(cbr_pkg::OFS_IRQ_PIN, (m == 0) ? 32'h0 : 32'h1);
      end
      for (int e = 0; e < 2; e++) begin
         subsys_write_enable_in <= e[0];
         d = $urandom;
         wr(cbr_pkg::OFS_MAKER_ID, d);
         wr(cbr_pkg::OFS_PRODUCT_ID, d >> 16);
         if (e == 1) {pr, mk} = d;
         rd(cbr_pkg::OFS_MAKER_ID, {16'h0, mk});
         rd(cbr_pkg::OFS_PRODUCT_ID, {16'h0, pr});
      end
      d = $urandom;
      wr(cbr_pkg::OFS_LEGACY_BASE, d);
      base = d | 32'h1;
      rd(cbr_pkg::OFS_LEGACY_BASE, base);
      cyc(1'b1, 1'b0, base & ~32'h1);
      `CHK("ports", 2'h2, {index_port_hit_out, data_port_hit_out})
      cyc(1'b1, 1'b0, base);
      `CHK("ports", 2'h1, {index_port_hit_out, data_port_hit_out})
      wr_bc(1, 16'h0000);
      wr_bc(0, 16'h000C);
      for (int i = 0; i < 8; i++) begin
         d = $urandom & 32'h0001_FFFF;
         cycle_socket_in <= i[0];
         cyc(1'b1, 1'b0, d);
         `CHK("isa", d < 32'h10000 && d[9:8] != 2'h0 && bcs[i % 2][2], isa_range_block_out)
      end
      cyc(1'b0, 1'b1, 32'h000A_0000);
      `CHK("vga", 1'b1, vga_forward_hit_out)
      cyc(1'b0, 1'b1, 32'h000C_0000);
      `CHK("vga", 1'b0, vga_forward_hit_out)
      wr_bc(0, 16'h0023);
      wr(cbr_pkg::OFS_EVENT_MASK, 32'h7);
      host_serr_enable_in <= 1'b1;
      fire <= 3'b110;
      @(posedge ref_clk_in);
      fire <= 3'b000;
      @(posedge ref_clk_in);
      #1;
      `CHK("abort", 3'h7, {target_abort_out, host_serr_out, card_parity_error_oe_out})
      @(posedge ref_clk_in);
      #1;
      `CHK("irq", 1'b1, irq_out)
      rd(cbr_pkg::OFS_EVENT_STATUS, 32'h6);
      @(posedge ref_clk_in);
      #1;
      `CHK("irq", 1'b0, irq_out)
      fire <= 3'b001;
      seen = 1'b0;
      for (int k = 0; k < 10 && !seen; k++) begin
         @(posedge ref_clk_in);
         fire <= 3'b000;
         #1;
         seen = host_serr_out === 1'b1;
      end
      `CHK("serr", 1'b1, seen)
      if (!seen) summarize();
      wr(cbr_pkg::OFS_EVENT_MASK, 32'h0);
      rd(cbr_pkg::OFS_EVENT_STATUS, 32'h1);
      wr_bc(0, 16'h0000);
      fire <= 3'b110;
      repeat (2) @(posedge ref_clk_in);
      fire <= 3'b000;
      #1;
      `CHK("quiet", 3'h0, {target_abort_out, card_parity_error_oe_out, irq_out})
      `CHK("card_reset_out", 1'b1, card_reset_n_out)
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      `CHK("card_reset_out", 1'b0, card_reset_n_out)
      summarize();
   end
endmodule : cbr_config_regs_bench

`default_nettype wire

//--- tb/cbr_config_regs_monitor.sv
// checker for the card bridge register group
// assumes it is bound into cbr_config_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module cbr_monitor (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        cycle_io_in,
   input wire logic [31:0] cycle_addr_in,
   input wire logic        master_abort_in,
   input wire logic        parity_error_detect_in,
   input wire logic        write_post_enable_out,
   input wire logic        window0_prefetchable_out,
   input wire logic        func_irq_route_sel_out,
   input wire logic        card_reset_n_out,
   input wire logic        target_abort_out,
   input wire logic        card_parity_error_n_out,
   input wire logic        card_parity_error_oe_out,
   input wire logic        isa_range_block_out,
   input wire logic        index_port_hit_out,
   input wire logic        data_port_hit_out,
   input wire logic [1:0]  irq_signal_mode_sel_out
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_rd(a);
      reg_rd_in && reg_addr_in == a;
   endsequence
   sequence s_ctl_wr;
      reg_wr_in && reg_addr_in == cbr_pkg::OFS_BRIDGE_CTL;
   endsequence
   a_ctl_outputs: assert property (s_ctl_wr |=>
      write_post_enable_out == $past(reg_wdata_in[10]) &&
      window0_prefetchable_out == $past(reg_wdata_in[8]) &&
      func_irq_route_sel_out == $past(reg_wdata_in[7]) &&
      card_reset_n_out == !$past(reg_wdata_in[6]))
      else $error("bridge control outputs wrong");
   a_pin_read: assert property (s_rd(cbr_pkg::OFS_IRQ_PIN) |=>
      reg_rdata_out == {31'h0, |irq_signal_mode_sel_out})
      else $error("interrupt pin value wrong");
   a_reserved_zero: assert property (s_rd(cbr_pkg::OFS_BRIDGE_CTL) |=>
      reg_rdata_out[15:11] == 5'h0 && !reg_rdata_out[4])
      else $error("reserved bridge bits not zero");
   a_legacy_bit0: assert property (s_rd(cbr_pkg::OFS_LEGACY_BASE) |=>
      reg_rdata_out[0])
      else $error("legacy base bit 0 not one");
   a_reset_state: assert property ($rose(rst_n_in) |->
      irq_signal_mode_sel_out == cbr_pkg::RST_MODE && !card_reset_n_out)
      else $error("state after reset wrong");
   a_abort_cause: assert property (target_abort_out |->
      $past(master_abort_in))
      else $error("target abort without master abort");
   a_parity_pulse: assert property (card_parity_error_oe_out |->
      !card_parity_error_n_out && $past(parity_error_detect_in))
      else $error("parity error drive without cause");
   a_isa_block: assert property (isa_range_block_out |->
      $past(cycle_io_in) && $past(cycle_addr_in[31:16]) == 16'h0 &&
      $past(cycle_addr_in[9:8]) != 2'h0)
      else $error("isa block outside its range");
   a_port_decode: assert property (
      (index_port_hit_out || data_port_hit_out) |-> $past(cycle_io_in) &&
      $past(cycle_addr_in[0]) == data_port_hit_out &&
      !(index_port_hit_out && data_port_hit_out))
      else $error("index or data port decode wrong");
endmodule : cbr_monitor

bind cbr_config_regs cbr_monitor u_cbr_monitor (.ref_clk_in, .rst_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .cycle_io_in, .cycle_addr_in, .master_abort_in, .parity_error_detect_in,
   .write_post_enable_out, .window0_prefetchable_out,
   .func_irq_route_sel_out, .card_reset_n_out, .target_abort_out,
   .card_parity_error_n_out, .card_parity_error_oe_out,
   .isa_range_block_out, .index_port_hit_out, .data_port_hit_out,
   .irq_signal_mode_sel_out);

`default_nettype wire
